// ---- cesh_pkg.sv ----
/*
  cesh_pkg: constants, types and register map for the channel enable and
  sync-word mode configuration block.
  assumes: compiled before every other file of the block.
*/
package cesh_pkg;

  // register byte addresses (printed offsets kept as indices, each x4)
  localparam logic [11:0] CESH_IDX_SYNC_MODE = 12'h20F;
  localparam logic [11:0] CESH_IDX_CH_PAIR   = 12'h209;
  localparam logic [11:0] CESH_IDX_LINK_CTL  = 12'h220;
  localparam logic [13:0] CESH_ADDR_SYNC_MODE = {CESH_IDX_SYNC_MODE, 2'b00};
  localparam logic [13:0] CESH_ADDR_CH_PAIR   = {CESH_IDX_CH_PAIR, 2'b00};
  localparam logic [13:0] CESH_ADDR_LINK_CTL  = {CESH_IDX_LINK_CTL, 2'b00};

  // channel pair enable fields
  localparam int CESH_POS_PAIR_ONE = 0;
  localparam int CESH_POS_PAIR_TWO = 1;
  localparam int CESH_POS_SINGLE   = 2;
  localparam logic [7:0] CESH_RST_CH_PAIR   = 8'h03;
  localparam logic [7:0] CESH_RST_SYNC_MODE = 8'h00;

  // link control fields
  localparam int CESH_POS_LINK_EN  = 0;
  localparam int CESH_POS_CAL_EN   = 1;
  localparam int CESH_POS_FMT_66B  = 2;
  localparam logic [7:0] CESH_RST_LINK_CTL = 8'h00;

  // configured lane and converter counts
  localparam logic [3:0] CESH_RST_LANES = 4'h8;
  localparam logic [3:0] CESH_RST_CONVS = 4'h4;

  localparam logic [1:0] CESH_SH_CRC12 = 2'h0;
  localparam logic [1:0] CESH_SH_FEC   = 2'h2;

  typedef enum logic [1:0] {
    CESH_SYNC_NONE,
    CESH_SYNC_CRC,
    CESH_SYNC_FEC
  } cesh_sync_e;

  // frame shape handed to the framer
  typedef struct packed {
    logic [3:0] lanes;
    logic [3:0] convs;
    logic       tail_pad;
    logic       swap_cd;
    logic [3:0] chan_on;
    logic [1:0] sync_sel;
    logic [3:0] cmd_bits;
  } cesh_frame_s;

  // one sample word with its slot in the frame
  typedef struct packed {
    logic [1:0]  slot;
    logic [15:0] sample;
  } cesh_samp_s;

endpackage : cesh_pkg

// ---- cesh_fifo.sv ----
/*
  cesh_fifo: synchronous valid/ready FIFO, width and depth parameters.
  assumes: single clock pclk, async active-low reset presetn.
*/
`timescale 1ns/100ps
`default_nettype none
module cesh_fifo
  import cesh_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
)(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end
endmodule // cesh_fifo
`default_nettype wire

// ---- cesh_top.sv ----
/*
  cesh_top: channel pair enables and sync-word mode registers over APB,
  frame shape derivation and sample slot remapping through a FIFO.
  assumes: APB3 master on pclk; samples arrive tagged with channel 0..3.
*/
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
//Contract
//- single channel select disables B, C, D; software keeps pair one set.
//- pair two enable, bit 1, reset one, enables channels C and D.
//- pair one enable, bit 0, reset one, enables channels A and B.
//- one pair off: lanes become ceil(L/2), converters M/2.
//- odd configured lane count in reduced mode pads tail bits, top lane.
//- pair one off: C and D samples take the A and B slots.
//- sync mode 0 sends CRC-12, 2 sends FEC, 1 and 3 reserved.
//- sync mode only acts while 64B/66B link format is selected.
//- command fields are always sent as zero, idle headers.
module cesh_top
  import cesh_pkg::*;
#(
  parameter int         FIFO_DEPTH = 32,
  parameter logic [3:0] CFG_LANES  = CESH_RST_LANES,
  parameter logic [3:0] CFG_CONVS  = CESH_RST_CONVS
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        samp_valid,
  output logic             samp_ready,
  input  wire logic [1:0]  samp_chan,
  input  wire logic [15:0] samp_data,
  output logic             slot_valid,
  input  wire logic        slot_ready,
  output cesh_samp_s       slot_out,
  output cesh_frame_s      frame_cfg,
  output logic             serial_link_enable,
  output logic             cal_enable
);
  logic [7:0]  channel_pair_enable;
  logic [7:0]  sync_word_mode_select;
  logic [7:0]  link_ctl;
  cesh_frame_s next_frame;
  cesh_samp_s  fifo_in;
  logic [31:0] rd_mux;

  // apb decode
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire hit_ch   = (paddr == CESH_ADDR_CH_PAIR);
  wire hit_sync = (paddr == CESH_ADDR_SYNC_MODE);
  wire hit_link = (paddr == CESH_ADDR_LINK_CTL);
  wire hit_any  = hit_ch || hit_sync || hit_link;

  assign pready  = 1'b1;
  assign pslverr = acc && !hit_any;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ch)
      rd_mux = {24'h00_0000, channel_pair_enable};
    else if (hit_sync)
      rd_mux = {24'h00_0000, sync_word_mode_select};
    else if (hit_link)
      rd_mux = {24'h00_0000, link_ctl};
  end

  // reserved bits are stored as written, software keeps them zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_pair_enable   <= CESH_RST_CH_PAIR;
      sync_word_mode_select <= CESH_RST_SYNC_MODE;
      link_ctl              <= CESH_RST_LINK_CTL;
    end
    else if (wr)
    begin
      if (hit_ch)
        channel_pair_enable <= pwdata[7:0];
      if (hit_sync)
        sync_word_mode_select <= pwdata[7:0];
      if (hit_link)
        link_ctl <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  assign serial_link_enable = link_ctl[CESH_POS_LINK_EN];
  assign cal_enable         = link_ctl[CESH_POS_CAL_EN];

  // frame shape
  wire single_channel_select = channel_pair_enable[CESH_POS_SINGLE];
  wire pair_two_enable       = channel_pair_enable[CESH_POS_PAIR_TWO];
  wire pair_one_enable       = channel_pair_enable[CESH_POS_PAIR_ONE];
  wire fmt_66b               = link_ctl[CESH_POS_FMT_66B];
  // single channel forces pair two off as well
  wire pair_two_on  = pair_two_enable && !single_channel_select;
  wire reduced      = pair_one_enable ^ pair_two_on;
  wire [3:0] half_l = 4'((CFG_LANES + 4'h1) >> 1);
  wire [3:0] half_m = 4'(CFG_CONVS >> 1);
  wire [3:0] chan_on_w = single_channel_select ?
                         4'b0001 :
                         {pair_two_on, pair_two_on,
                          pair_one_enable, pair_one_enable};
  wire [1:0] sync_w = (sync_word_mode_select[1:0] == CESH_SH_FEC) ?
                      2'(CESH_SYNC_FEC) : 2'(CESH_SYNC_CRC);

  always_comb
  begin
    next_frame          = '0;
    next_frame.lanes    = reduced ? half_l : CFG_LANES;
    next_frame.convs    = reduced ? half_m : CFG_CONVS;
    next_frame.tail_pad = reduced && CFG_LANES[0];
    next_frame.swap_cd  = !pair_one_enable && pair_two_on;
    next_frame.chan_on  = chan_on_w;
    // reserved codes fall back to crc so the link never goes silent
    next_frame.sync_sel = fmt_66b ? sync_w : 2'(CESH_SYNC_NONE);
    next_frame.cmd_bits = 4'h0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_cfg <= '0;
    else
      frame_cfg <= next_frame;
  end

  // sample slot remap: disabled channels are dropped, C/D move down
  wire chan_en  = chan_on_w[samp_chan];
  wire [1:0] sl = next_frame.swap_cd ? (samp_chan - 2'h2) : samp_chan;
  wire fifo_rdy;

  assign fifo_in.slot   = sl;
  assign fifo_in.sample = samp_data;
  // dropped samples are accepted so the source never stalls on them
  assign samp_ready = chan_en ? fifo_rdy : 1'b1;

  cesh_samp_s fifo_q;

  cesh_fifo #(
    .WIDTH ($bits(cesh_samp_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (samp_valid && chan_en),
    .in_ready  (fifo_rdy),
    .in_data   (fifo_in),
    .out_valid (slot_valid),
    .out_ready (slot_ready),
    .out_data  (fifo_q)
  );

  assign slot_out = fifo_q;
endmodule // cesh_top
`default_nettype wire

// ---- cesh_monitor.sv ----
/* cesh_monitor: port checks for cesh_top.
   assumes: bound into cesh_top, reads its ports only. */
`timescale 1ns/100ps
`default_nettype none
module cesh_monitor
  import cesh_pkg::*;
#(
  parameter logic [3:0] CFG_LANES = 4'h8,
  parameter logic [3:0] CFG_CONVS = 4'h4
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire cesh_frame_s frame_cfg
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr = psel && penable && pwrite;
  wire wr_ch = wr && paddr == CESH_ADDR_CH_PAIR;
  wire wr_lk = wr && paddr == CESH_ADDR_LINK_CTL;
  // single channel mode with pair one set also runs the link at half size
  wire half = frame_cfg.chan_on == 4'h3 || frame_cfg.chan_on == 4'hC
              || frame_cfg.chan_on == 4'h1;
  wire [3:0] half_l = 4'((CFG_LANES + 4'h1) >> 1);
  wire [3:0] half_m = 4'(CFG_CONVS >> 1);
  chk_pair_bits: assert property (wr_ch && !pwdata[2] |-> ##2
    frame_cfg.chan_on == {{2{$past(pwdata[1], 2)}}, {2{$past(pwdata[0], 2)}}})
    else $error("pair enables not applied");
  chk_single_only: assert property (wr_ch && pwdata[2] |-> ##2
    frame_cfg.chan_on == 4'h1) else $error("single channel wrong");
  chk_half_size: assert property (half |-> frame_cfg.convs == half_m
    && frame_cfg.lanes == half_l) else $error("half size");
  chk_full_size: assert property (frame_cfg.chan_on == 4'hF |->
    frame_cfg.convs == CFG_CONVS && frame_cfg.lanes == CFG_LANES)
    else $error("full size");
  chk_tail_pad: assert property (
    frame_cfg.tail_pad == (half && CFG_LANES[0])) else $error("tail pad");
  chk_swap_slot: assert property (
    frame_cfg.swap_cd == (frame_cfg.chan_on == 4'hC)) else $error("swap");
  chk_cmd_idle: assert property (
    frame_cfg.cmd_bits == 4'h0) else $error("command bits set");
  chk_fmt_gate: assert property (wr_lk && !pwdata[2] |-> ##2
    frame_cfg.sync_sel == CESH_SYNC_NONE) else $error("sync without 66b");
  chk_sync_code: assert property (
    frame_cfg.sync_sel != 2'h3) else $error("bad sync select");
endmodule // cesh_monitor
bind cesh_top cesh_monitor #(
  .CFG_LANES (CFG_LANES),
  .CFG_CONVS (CFG_CONVS)
) mon (
  .pclk      (pclk),
  .presetn   (presetn),
  .psel      (psel),
  .penable   (penable),
  .pwrite    (pwrite),
  .paddr     (paddr),
  .pwdata    (pwdata),
  .frame_cfg (frame_cfg)
);
`default_nettype wire

// ---- cesh_sink.sv ----
/* cesh_sink: framer side, takes slot words into a queue.
   assumes: mode 0 prompt, 1 every other cycle, 2 held off. */
`timescale 1ns/100ps
`default_nettype none
module cesh_sink
  import cesh_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] mode,
  input  wire logic       slot_valid,
  input  wire cesh_samp_s slot_out,
  output logic            slot_ready
);
  cesh_samp_s q[$];
  logic       tog;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tog <= 1'b0;
    else
    begin
      tog <= ~tog;
      if (slot_valid && slot_ready)
        q.push_back(slot_out);
    end
  end
  assign slot_ready = mode == 2'h0 || (mode == 2'h1 && tog);
endmodule // cesh_sink
`default_nettype wire

// ---- cesh_top_tb_top.sv ----
/* cesh_top_tb_top: register and sample path tests of cesh_top.
   assumes: cesh_sink as far side, monitor bound separately. */
`timescale 1ns/100ps
`default_nettype none
module cesh_top_tb_top
  import cesh_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, samp_valid = 1'b0, pready, pslverr, samp_ready, serr;
  logic slot_valid, slot_ready, serial_link_enable, cal_enable;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [1:0]  samp_chan = '0, mode = 2'h0;
  logic [15:0] samp_data = '0;
  cesh_samp_s  slot_out;
  cesh_frame_s frame_cfg;
  int failures = 0, n_tests = 0;
  logic [2:0] cfg [4] = '{3'h3, 3'h1, 3'h2, 3'h5};
  logic [3:0] on [4] = '{4'hF, 4'h3, 4'hC, 4'h1};
  logic [7:0] sz [4] = '{8'h74, 8'h42, 8'h42, 8'h42};
  always #10 pclk = ~pclk;
  cesh_top #(.CFG_LANES(4'h7)) uut (.*);
  cesh_sink snk (.*);
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // request held until the edge at which pready is seen high
  task automatic apb(logic w, logic [13:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic snd(logic [1:0] c, logic [15:0] v);
    @(posedge pclk);
    samp_valid <= 1'b1;
    samp_chan <= c;
    samp_data <= v;
    do
    begin
      @(posedge pclk);
    end
    while (samp_ready !== 1'b1);
    samp_valid <= 1'b0;
  endtask
  task automatic wrap_up;
    if (failures == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #1000000;
    failures++;
    wrap_up;
  end
  initial
  begin
    cesh_samp_s s;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, CESH_ADDR_CH_PAIR, 0);
    chk("ch_pair", 32'h3, rdat);
    apb(0, CESH_ADDR_SYNC_MODE, 0);
    chk("sync_mode", 32'h0, rdat);
    apb(1, CESH_ADDR_LINK_CTL, 32'h4);
    for (int m = 0; m < 4; m++)
    begin
      apb(1, CESH_ADDR_SYNC_MODE, m);
      repeat (2) @(negedge pclk);
      chk("sync_sel", m == 2 ? 2 : 1, frame_cfg.sync_sel);
    end
    apb(1, CESH_ADDR_LINK_CTL, 32'h0);
    repeat (2) @(negedge pclk);
    chk("sync_off", 0, frame_cfg.sync_sel);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, CESH_ADDR_CH_PAIR, cfg[k]);
      mode <= {1'b0, k[0]};
      repeat (2) @(negedge pclk);
      chk("chan_on", on[k], frame_cfg.chan_on);
      chk("size", sz[k], {frame_cfg.lanes, frame_cfg.convs});
      for (int c = 0; c < 4; c++)
        snd(c, 16'hA000 + c);
      for (int i = 0; i < 60; i++)
        @(negedge pclk);
      chk("slots", $countones(on[k]), snk.q.size());
      for (int c = 0; c < 4; c++)
        if (on[k][c] && snk.q.size() > 0)
        begin
          s = snk.q.pop_front();
          chk("slot", {c[1:0] - (on[k] == 4'hC ? 2'h2 : 2'h0),
            16'hA000 + c[15:0]}, s);
        end
    end
    @(posedge pclk);
    mode <= 2'h2;
    for (int i = 0; i < 32; i++)
      snd(0, i);
    @(negedge pclk);
    chk("full", 0, samp_ready);
    @(posedge pclk);
    mode <= 2'h0;
    for (int i = 0; i < 80; i++)
      @(negedge pclk);
    chk("drained", 32, snk.q.size());
    chk("empty", 0, slot_valid);
    for (int i = 0; i < 32; i++)
      if (snk.q.size() > 0)
      begin
        s = snk.q.pop_front();
        chk("fifo_order", {2'h0, i[15:0]}, s);
      end
    apb(0, CESH_ADDR_CH_PAIR, 0);
    chk("ch_back", 32'h5, rdat);
    apb(0, 14'h0000, 0);
    chk("slverr", 1, serr);
    chk("unmapped", 0, rdat);
    apb(1, CESH_ADDR_LINK_CTL, 32'h3);
    @(negedge pclk);
    chk("link_en", 1, serial_link_enable);
    chk("cal_en", 1, cal_enable);
    wrap_up;
  end
endmodule // cesh_top_tb_top
`default_nettype wire
